/* File: hdl/ois_irq_status.sv */
`timescale 1ns/1ps
// Behaviour
// - Any event sets its flag; flag stays set until software clears it.
// - Host interrupt needs flag, its mask bit and gate bit 31 all set.
// - Writing one clears a flag, zero keeps it; software never sets flags.
// - Flags register is 32 bits at 0Ch, reset to zero.
// - Ownership flag bit 30 sets when request bit 3 is written.
// - Unmasked ownership flag raises management interrupt at once.
// - Without management pin the ownership flag stays zero.
// - Root port flag bit 6 sets on any hub or port state change.
// - Rollover flag bit 5 sets on frame bit 15 toggle after update.
// - Fatal error sets bit 4 and halts processing until cleared.
// - Resume flag bit 3 sets when device resume signaling starts.
// - Resume flag not set by software-entered resume state.
// - Frame start flag bit 2 sets with the SOF token.
// - Done flag bit 1 sets right after done pointer write-back.
// - While done flag is set, no further done pointer update.
// - Overrun flag bit 0 sets on schedule overrun after frame update.
// - Each overrun increments the two-bit tally in bits 17 to 16.
// - Mask set register at 10h: ones set mask bits, reads mask.
// - Tally starts at zero, wraps, increments even if flag set.
// - Mask clear register at 14h: ones clear mask bits, reads mask.
module ois_irq_status #(
  parameter int          NUM_PORTS     = 2,
  parameter bit          MGMT_IRQ_IMPL = 1'b1
) (
  // Clock and reset
  input  wire  logic                      pclk,
  input  wire  logic                      presetn,
  // APB slave
  input  wire  logic                      psel,
  input  wire  logic                      penable,
  input  wire  logic                      pwrite,
  input  wire  logic [7:0]                paddr,
  input  wire  logic [31:0]               pwdata,
  output logic [31:0]                     prdata,
  output logic                            pready,
  output logic                            pslverr,
  // Core events and state
  input  wire  ois_pkg::ois_ev_t          ev_i,
  input  wire  logic [15:0]               frame_counter,
  input  wire  logic [31:0]               root_hub_state,
  input  wire  logic [NUM_PORTS*32-1:0]   port_state,
  // Core controls and interrupts
  output logic                            host_irq,
  output logic                            mgmt_irq,
  output logic                            halt,
  output logic                            done_upd_allow,
  output logic                            ownership_change_request,
  output logic [1:0]                      overrun_tally
);
  import ois_pkg::*;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic        wr_acc;
  logic        rd_setup;
  logic        hit;
  logic [31:0] st_clr;
  logic [31:0] msk_set;
  logic [31:0] msk_clr;
  logic        req_wr;

  // Writes take effect in the access phase; slave never waits
  always_comb begin
    wr_acc   = psel && penable && pwrite;
    rd_setup = psel && !penable && !pwrite;
    hit      = (paddr == OIS_OFS_CMD_STATUS) || (paddr == OIS_OFS_FLAGS) ||
               (paddr == OIS_OFS_MASK_SET) || (paddr == OIS_OFS_MASK_CLR);
    st_clr   = (wr_acc && paddr == OIS_OFS_FLAGS) ? (pwdata & OIS_FLAG_BITS)
                                                  : OIS_RST_WORD;
    msk_set  = (wr_acc && paddr == OIS_OFS_MASK_SET) ? (pwdata & OIS_MASK_BITS)
                                                     : OIS_RST_WORD;
    msk_clr  = (wr_acc && paddr == OIS_OFS_MASK_CLR) ? (pwdata & OIS_MASK_BITS)
                                                     : OIS_RST_WORD;
    req_wr   = wr_acc && (paddr == OIS_OFS_CMD_STATUS) && pwdata[OIS_B_OWN_REQ];
  end

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;

  // ----------------------------------------------------------------
  // Event detection
  // ----------------------------------------------------------------
  logic [NUM_PORTS:0] chg;
  logic [31:0]        snap_q [NUM_PORTS+1];
  logic [31:0]        snap_d [NUM_PORTS+1];
  logic               snap_vld_q;
  logic               res_q;
  logic               msb_q;
  logic               msb_d;
  logic               res_rise;
  logic               roll_ev;

  // Per-register change compare against the last seen content
  genvar gi;
  generate
    for (gi = 0; gi <= NUM_PORTS; gi++) begin : g_chg
      if (gi == 0) begin : g_hub
        assign snap_d[gi] = root_hub_state;
      end else begin : g_port
        assign snap_d[gi] = port_state[(gi-1)*32 +: 32];
      end
      assign chg[gi] = snap_vld_q && (snap_d[gi] != snap_q[gi]);
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          snap_q[gi] <= OIS_RST_WORD;
        end else begin
          snap_q[gi] <= snap_d[gi];
        end
      end
    end
  endgenerate

  // Frame MSB is sampled only at shared frame number updates
  always_comb begin
    msb_d    = ev_i.frame_upd ? frame_counter[OIS_B_FRM_MSB] : msb_q;
    roll_ev  = ev_i.frame_upd && (frame_counter[OIS_B_FRM_MSB] != msb_q);
    res_rise = ev_i.resume_sig && !res_q && !ev_i.sw_resume;
  end

  // Edge and history registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      snap_vld_q <= 1'b0;
      res_q      <= 1'b0;
      msb_q      <= 1'b0;
    end else begin
      snap_vld_q <= 1'b1;
      res_q      <= ev_i.resume_sig;
      msb_q      <= msb_d;
    end
  end

  // ----------------------------------------------------------------
  // Flags, mask, command status
  // ----------------------------------------------------------------
  logic [31:0] flags_q;
  logic [31:0] flags_d;
  logic [31:0] set_ev;
  logic [31:0] mask_q;
  logic [31:0] mask_d;
  logic        own_req_q;
  logic        own_req_d;
  logic [1:0]  tally_q;
  logic [1:0]  tally_d;
  logic        host_d;
  logic        mgmt_d;

  // Next state; a set in the same cycle as a clear wins
  always_comb begin
    set_ev                 = OIS_RST_WORD;
    set_ev[OIS_B_OVERRUN]  = ev_i.overrun;
    set_ev[OIS_B_DONE]     = ev_i.done_wb;
    set_ev[OIS_B_SOF]      = ev_i.sof;
    set_ev[OIS_B_RESUME]   = res_rise;
    set_ev[OIS_B_FATAL]    = ev_i.sys_err;
    set_ev[OIS_B_ROLLOVER] = roll_ev;
    set_ev[OIS_B_ROOT]     = |chg;
    set_ev[OIS_B_OWNER]    = MGMT_IRQ_IMPL && req_wr;
    flags_d = ((flags_q & ~st_clr) | set_ev) & OIS_FLAG_BITS;
    mask_d  = ((mask_q & ~msk_clr) | msk_set) & OIS_MASK_BITS;
    own_req_d = req_wr ? 1'b1 : (ev_i.owner_done ? 1'b0 : own_req_q);
    tally_d = ev_i.overrun ? tally_q + 2'h1 : tally_q;
    host_d  = mask_d[OIS_B_GATE] &&
              |(flags_d & mask_d & OIS_HOST_BITS);
    mgmt_d  = flags_d[OIS_B_OWNER] && mask_d[OIS_B_OWNER];
  end

  // State registers, all zero after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q  <= OIS_RST_WORD;
      mask_q   <= OIS_RST_WORD;
      own_req_q <= 1'b0;
      tally_q  <= OIS_TALLY_RST;
      host_irq <= 1'b0;
      mgmt_irq <= 1'b0;
    end else begin
      flags_q  <= flags_d;
      mask_q   <= mask_d;
      own_req_q <= own_req_d;
      tally_q  <= tally_d;
      host_irq <= host_d;
      mgmt_irq <= mgmt_d;
    end
  end

  // Core controls
  assign halt                     = flags_q[OIS_B_FATAL];
  assign done_upd_allow           = !flags_q[OIS_B_DONE];
  assign ownership_change_request = own_req_q;
  assign overrun_tally            = tally_q;

  // ----------------------------------------------------------------
  // Read data, captured in the setup phase
  // ----------------------------------------------------------------
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  // Mux of the addressed register; unmapped reads zero
  always_comb begin
    rdata_d = rdata_q;
    if (rd_setup) begin
      case (paddr)
        OIS_OFS_CMD_STATUS: begin
          rdata_d                            = OIS_RST_WORD;
          rdata_d[OIS_B_OWN_REQ]             = own_req_q;
          rdata_d[OIS_B_TALLY+1:OIS_B_TALLY] = tally_q;
        end
        OIS_OFS_FLAGS:    rdata_d = flags_q;
        OIS_OFS_MASK_SET: rdata_d = mask_q;
        OIS_OFS_MASK_CLR: rdata_d = mask_q;
        default:          rdata_d = OIS_RST_WORD;
      endcase
    end
  end

  // Read data register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= OIS_RST_WORD;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign prdata = rdata_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_sticky;
    1 |=> ((($past(flags_q) & ~$past(st_clr)) & ~flags_q) == 32'h0000_0000);
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost without clear");

  property p_irq_level;
    host_irq == (mask_q[OIS_B_GATE] && |(flags_q & mask_q & OIS_HOST_BITS));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("host irq mismatch");

  property p_w1c;
    (wr_acc && paddr == OIS_OFS_FLAGS && pwdata[OIS_B_SOF] && !ev_i.sof)
      |=> !flags_q[OIS_B_SOF];
  endproperty
  a_w1c: assert property (p_w1c) else $error("frame start flag not cleared");

  property p_no_sw_set;
    $rose(flags_q[OIS_B_SOF]) |-> $past(ev_i.sof);
  endproperty
  a_no_sw_set: assert property (p_no_sw_set) else $error("flag set without event");

  property p_owner;
    req_wr |=> (flags_q[OIS_B_OWNER] == MGMT_IRQ_IMPL);
  endproperty
  a_owner: assert property (p_owner) else $error("ownership flag wrong");

  property p_resume;
    $rose(flags_q[OIS_B_RESUME]) |-> $past(ev_i.resume_sig && !res_q && !ev_i.sw_resume);
  endproperty
  a_resume: assert property (p_resume) else $error("resume flag bad cause");

  property p_tally;
    ev_i.overrun |=> (tally_q == 2'($past(tally_q) + 2'h1));
  endproperty
  a_tally: assert property (p_tally) else $error("tally not incremented");

  property p_done_hold;
    flags_q[OIS_B_DONE] |-> !done_upd_allow;
  endproperty
  a_done_hold: assert property (p_done_hold) else $error("done update not held");

  property p_mask_set;
    (wr_acc && paddr == OIS_OFS_MASK_SET)
      |=> ((mask_q & $past(pwdata) & OIS_MASK_BITS) == ($past(pwdata) & OIS_MASK_BITS));
  endproperty
  a_mask_set: assert property (p_mask_set) else $error("mask bits not set");

  property p_mask_clr;
    (wr_acc && paddr == OIS_OFS_MASK_CLR) |=> ((mask_q & $past(pwdata)) == 32'h0000_0000);
  endproperty
  a_mask_clr: assert property (p_mask_clr) else $error("mask bits not cleared");

  property p_mgmt;
    (flags_q[OIS_B_OWNER] && mask_q[OIS_B_OWNER]) |-> mgmt_irq;
  endproperty
  a_mgmt: assert property (p_mgmt) else $error("management irq missing");

  property p_halt;
    ev_i.sys_err |=> halt [*2];
  endproperty
  a_halt: assert property (p_halt) else $error("halt not raised");

  // Done write-back withholds the next pointer update at once
  property p_done_set;
    ev_i.done_wb |=> !done_upd_allow;
  endproperty
  a_done_set: assert property (p_done_set) else $error("done not withheld");

  // Frame MSB change at a frame number update sets the rollover flag
  property p_roll;
    (ev_i.frame_upd && (frame_counter[OIS_B_FRM_MSB] != msb_q)) |=> flags_q[OIS_B_ROLLOVER];
  endproperty
  a_roll: assert property (p_roll) else $error("rollover flag not set");

  // Hub state change after arming sets the root port flag
  property p_root;
    (snap_vld_q && (root_hub_state != snap_q[0])) |=> flags_q[OIS_B_ROOT];
  endproperty
  a_root: assert property (p_root) else $error("root port flag not set");

  // Ownership flag only exists with the management pin
  property p_owner_impl;
    flags_q[OIS_B_OWNER] |-> MGMT_IRQ_IMPL;
  endproperty
  a_owner_impl: assert property (p_owner_impl) else $error("flag without pin");

  // Gate off keeps the host interrupt low
  property p_gate_off;
    !mask_q[OIS_B_GATE] |-> !host_irq;
  endproperty
  a_gate_off: assert property (p_gate_off) else $error("host irq without gate");

  // Fatal error sets its flag on the next edge
  property p_fatal_set;
    ev_i.sys_err |=> flags_q[OIS_B_FATAL];
  endproperty
  a_fatal_set: assert property (p_fatal_set) else $error("fatal flag not set");

  // Overrun sets its flag on the next edge
  property p_overrun_set;
    ev_i.overrun |=> flags_q[OIS_B_OVERRUN];
  endproperty
  a_overrun_set: assert property (p_overrun_set) else $error("overrun unseen");

  // Command status write of the request bit raises the request output
  property p_req_set;
    req_wr |=> ownership_change_request;
  endproperty
  a_req_set: assert property (p_req_set) else $error("request not raised");

  // Tally holds when no overrun arrives
  property p_tally_hold;
    !ev_i.overrun |=> (tally_q == $past(tally_q));
  endproperty
  a_tally_hold: assert property (p_tally_hold) else $error("tally moved");

  // Frame start sets its flag on the edge after the token
  property p_sof_set;
    ev_i.sof |=> flags_q[OIS_B_SOF];
  endproperty
  a_sof_set: assert property (p_sof_set) else $error("frame start flag not set");

  // Management interrupt stays low while its mask bit is clear
  property p_mgmt_off;
    !mask_q[OIS_B_OWNER] |-> !mgmt_irq;
  endproperty
  a_mgmt_off: assert property (p_mgmt_off) else $error("management irq unmasked");

  c_host_irq: cover property (ev_i.sof ##1 host_irq ##[1:20] !host_irq);
  c_wrap:     cover property (tally_q == 2'h3 ##[1:50] tally_q == 2'h0);
  c_root_chg: cover property (|chg ##1 flags_q[OIS_B_ROOT]);
  c_fatal:    cover property (ev_i.sys_err ##1 halt);
  c_owner:    cover property (req_wr ##1 mgmt_irq);

endmodule

/* File: hdl/ois_pkg.sv */
package ois_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  OIS_OFS_CMD_STATUS = 8'h08;
  localparam logic [7:0]  OIS_OFS_FLAGS      = 8'h0C;
  localparam logic [7:0]  OIS_OFS_MASK_SET   = 8'h10;
  localparam logic [7:0]  OIS_OFS_MASK_CLR   = 8'h14;
  localparam logic [31:0] OIS_RST_WORD       = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int OIS_B_OVERRUN  = 0;
  localparam int OIS_B_DONE     = 1;
  localparam int OIS_B_SOF      = 2;
  localparam int OIS_B_RESUME   = 3;
  localparam int OIS_B_FATAL    = 4;
  localparam int OIS_B_ROLLOVER = 5;
  localparam int OIS_B_ROOT     = 6;
  localparam int OIS_B_OWNER    = 30;
  localparam int OIS_B_GATE     = 31;
  localparam int OIS_B_OWN_REQ  = 3;
  localparam int OIS_B_TALLY    = 16;
  localparam int OIS_B_FRM_MSB  = 15;

  // Writable bits of each register; everything else reads zero
  localparam logic [31:0] OIS_FLAG_BITS = 32'h4000_007F;
  localparam logic [31:0] OIS_MASK_BITS = 32'hC000_007F;
  localparam logic [31:0] OIS_HOST_BITS = 32'h0000_007F;
  localparam logic [1:0]  OIS_TALLY_RST = 2'h0;

  // ----------------------------------------------------------------
  // Event pulses from the host controller core (pclk domain)
  // ----------------------------------------------------------------
  typedef struct packed {
    logic sof;          // SOF token issued this cycle
    logic done_wb;      // Done pointer copied to shared memory
    logic overrun;      // Schedule overrun in current frame
    logic frame_upd;    // Shared frame number written
    logic sys_err;      // Non-USB system error
    logic resume_sig;   // Level: downstream device drives resume
    logic sw_resume;    // Level: software placed core in resume
    logic owner_done;   // Ownership handover finished
  } ois_ev_t;

endpackage

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import ois_pkg::*;

  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  ois_ev_t     ev_i = '0;
  logic [15:0] frame_counter = 16'h0000;
  logic [31:0] root_hub_state = 32'h0000_0000;
  logic [63:0] port_state = 64'h0000_0000_0000_0000;
  logic        host_irq;
  logic        mgmt_irq;
  logic        halt;
  logic        done_upd_allow;
  logic        own_req;
  logic [1:0]  overrun_tally;
  int          err_count = 0;
  int          n_checks = 0;

  // Half period of a 40 MHz clock
  always #12.5 pclk = ~pclk;

  ois_irq_status i_dut (
    .pclk                     (pclk),
    .presetn                  (presetn),
    .psel                     (psel),
    .penable                  (penable),
    .pwrite                   (pwrite),
    .paddr                    (paddr),
    .pwdata                   (pwdata),
    .prdata                   (prdata),
    .pready                   (pready),
    .pslverr                  (pslverr),
    .ev_i                     (ev_i),
    .frame_counter            (frame_counter),
    .root_hub_state           (root_hub_state),
    .port_state               (port_state),
    .host_irq                 (host_irq),
    .mgmt_irq                 (mgmt_irq),
    .halt                     (halt),
    .done_upd_allow           (done_upd_allow),
    .ownership_change_request (own_req),
    .overrun_tally            (overrun_tally)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic print_verdict();
    if (err_count == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int i;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      err_count++;
      $display("MISMATCH at %0t: no pready", $time);
      print_verdict();
    end else begin
      rd      = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk(r, exp);
    chk({31'h0, e}, 32'h0000_0000);
  endtask

  task automatic settle();
    @(posedge pclk);
    #1;
  endtask

  // One-cycle event pulse, observed one cycle later
  task automatic pulse(input ois_ev_t v);
    @(posedge pclk);
    ev_i <= v;
    @(posedge pclk);
    ev_i <= '0;
    #1;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk({25'h0, host_irq, mgmt_irq, halt, own_req, overrun_tally, done_upd_allow},
        32'h0000_0001);
    rd(OIS_OFS_FLAGS, 32'h0000_0000);
    rd(OIS_OFS_MASK_SET, 32'h0000_0000);
    rd(OIS_OFS_CMD_STATUS, 32'h0000_0000);
  endtask

  task automatic t_gate();
    ois_ev_t v;
    v = '0;
    v.sof = 1'b1;
    wr(OIS_OFS_MASK_SET, 32'h8000_0004);
    pulse(v);
    chk({31'h0, host_irq}, 32'h0000_0001);
    wr(OIS_OFS_FLAGS, 32'h0000_0000);
    rd(OIS_OFS_FLAGS, 32'h0000_0004);
    wr(OIS_OFS_MASK_CLR, 32'h8000_0000);
    settle();
    chk({31'h0, host_irq}, 32'h0000_0000);
    rd(OIS_OFS_MASK_CLR, 32'h0000_0004);
    wr(OIS_OFS_MASK_SET, 32'h8000_0000);
    settle();
    chk({31'h0, host_irq}, 32'h0000_0001);
    wr(OIS_OFS_FLAGS, 32'h0000_0004);
    settle();
    chk({31'h0, host_irq}, 32'h0000_0000);
    rd(OIS_OFS_FLAGS, 32'h0000_0000);
  endtask

  task automatic t_events();
    ois_ev_t     v;
    logic [31:0] b;
    wr(OIS_OFS_MASK_SET, 32'hC000_007F);
    rd(OIS_OFS_MASK_SET, 32'hC000_007F);
    for (int k = 0; k < 3; k++) begin
      v         = '0;
      v.overrun = (k == 0);
      v.done_wb = (k == 1);
      v.sof     = (k == 2);
      b         = 32'h0000_0001 << k;
      pulse(v);
      chk({29'h0, host_irq, halt, done_upd_allow}, {29'h0, 2'h2, ~b[1]});
      rd(OIS_OFS_FLAGS, b);
      wr(OIS_OFS_FLAGS, b);
      settle();
      chk({30'h0, host_irq, done_upd_allow}, 32'h0000_0001);
    end
    // Fatal error halts the core until the flag is cleared; here a reset clears it
    v         = '0;
    v.sys_err = 1'b1;
    pulse(v);
    chk({30'h0, host_irq, halt}, 32'h0000_0003);
    rd(OIS_OFS_FLAGS, 32'h0000_0010);
    chk({31'h0, halt}, 32'h0000_0001);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    wr(OIS_OFS_FLAGS, 32'h0000_0010);
    settle();
    chk({28'h0, host_irq, halt, mgmt_irq, done_upd_allow}, 32'h0000_0001);
    rd(OIS_OFS_FLAGS, 32'h0000_0000);
    rd(OIS_OFS_CMD_STATUS, 32'h0000_0000);
    wr(OIS_OFS_MASK_SET, 32'hC000_007F);
  endtask

  task automatic t_tally();
    ois_ev_t v;
    v = '0;
    v.overrun = 1'b1;
    for (int k = 1; k <= 4; k++) begin
      pulse(v);
      chk({30'h0, overrun_tally}, k % 4);
    end
    rd(OIS_OFS_CMD_STATUS, 32'h0000_0000);
    wr(OIS_OFS_FLAGS, 32'h0000_0001);
  endtask

  task automatic t_frame_resume_root();
    ois_ev_t v;
    v = '0;
    v.frame_upd = 1'b1;
    pulse(v);
    rd(OIS_OFS_FLAGS, 32'h0000_0000);
    frame_counter <= 16'h8000;
    pulse(v);
    rd(OIS_OFS_FLAGS, 32'h0000_0020);
    wr(OIS_OFS_FLAGS, 32'h0000_0020);
    pulse(v);
    rd(OIS_OFS_FLAGS, 32'h0000_0000);
    v = '0;
    v.resume_sig = 1'b1;
    v.sw_resume = 1'b1;
    pulse(v);
    rd(OIS_OFS_FLAGS, 32'h0000_0000);
    v.sw_resume = 1'b0;
    pulse(v);
    rd(OIS_OFS_FLAGS, 32'h0000_0008);
    wr(OIS_OFS_FLAGS, 32'h0000_0008);
    port_state[40] <= 1'b1;
    settle();
    settle();
    rd(OIS_OFS_FLAGS, 32'h0000_0040);
    wr(OIS_OFS_FLAGS, 32'h0000_0040);
    root_hub_state[2] <= 1'b1;
    settle();
    settle();
    rd(OIS_OFS_FLAGS, 32'h0000_0040);
    wr(OIS_OFS_FLAGS, 32'h0000_0040);
  endtask

  task automatic t_owner();
    ois_ev_t     v;
    logic [31:0] r;
    logic        e;
    v = '0;
    v.owner_done = 1'b1;
    wr(OIS_OFS_CMD_STATUS, 32'h0000_0008);
    settle();
    chk({29'h0, own_req, mgmt_irq, host_irq}, 32'h0000_0006);
    rd(OIS_OFS_FLAGS, 32'h4000_0000);
    pulse(v);
    chk({31'h0, own_req}, 32'h0000_0000);
    wr(OIS_OFS_FLAGS, 32'h4000_0000);
    settle();
    chk({31'h0, mgmt_irq}, 32'h0000_0000);
    wr(OIS_OFS_FLAGS, 32'h4000_007F);
    rd(OIS_OFS_FLAGS, 32'h0000_0000);
    apb(1'b0, 8'h20, 32'h0000_0000, r, e);
    chk({e, r[30:0]}, 32'h8000_0000);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    settle();
    t_reset();
    t_gate();
    t_events();
    t_tally();
    t_frame_resume_root();
    t_owner();
    print_verdict();
  end

endmodule
